// ---- src/pbf_pkg.sv ----
// shared constants, types and register map of the bank access front end
`default_nettype none
package pbf_pkg;
  // register indices on the plain register port
  localparam logic [3:0] REG_BASE_CFG = 4'h0;
  localparam logic [3:0] REG_REFR_CFG = 4'h1;
  localparam logic [3:0] REG_ORG      = 4'h2;
  localparam logic [3:0] REG_STATUS   = 4'h3;
  localparam logic [3:0] REG_REFUSED  = 4'h4;
  // field positions
  localparam int BASE_CHOICE_BIT  = 0;
  localparam int BASE_FIXCHOP_BIT = 1;
  localparam int BASE_BUFONLY_BIT = 13;
  localparam int REFR_STORE_BIT   = 8;
  localparam int ORG_WIDE_BIT     = 0;
  localparam int STAT_BUSY_BIT    = 16;
  localparam int AUTO_CLOSE_BIT   = 10;
  localparam int BURST_LEN_BIT    = 12;
  // reset values
  localparam logic [31:0] BASE_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] REFR_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] ORG_RST      = 32'h0000_0000;
  // timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int STORE_PERIOD_NS = 380;
  localparam int STORE_CYC       = (STORE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // core clocks per burst, two beats per clock
  localparam int FULL_CLKS = 4;
  localparam int CHOP_CLKS = 2;
  localparam int NUM_BANKS = 16;
  localparam int ROW_W     = 16;
  localparam int COL_W     = 7;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD  = 3'h2,
    CMD_WR  = 3'h3,
    CMD_REF = 3'h4,
    CMD_PRE = 3'h5
  } pbf_cmd_code_t;

  typedef struct packed {
    pbf_cmd_code_t code;
    logic [1:0]    group_select_bits;
    logic [1:0]    bank;
    logic [15:0]   addr;
  } pbf_cmd_t;

  typedef struct packed {
    logic              is_write;
    logic [3:0]        bank_idx;
    logic [ROW_W-1:0]  row;
    logic [COL_W-1:0]  col;
    logic              chop;
    logic              auto_close;
    logic              commit;
  } pbf_burst_t;
endpackage
`default_nettype wire

// ---- src/pbf_fifo.sv ----
// small valid/ready buffer for burst descriptors
`default_nettype none
module pbf_fifo #(
  parameter int W     = 31,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0]   count_r;
  logic          push;
  logic          pop;

  assign in_ready  = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- src/pbf_front_end.sv ----
// command decode, bank tracking, store timing and burst sequencing
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`default_nettype none
//
// Contract
// - x8: sixteen banks in four groups
// - x16: two groups of four banks
// - one 8n word over four clocks
// - burst of eight, or chopped four
// - activate captures group, bank and row
// - read/write address is start column
// - auto close bit decides precharge
// - per-command choice picks burst length
// - no refresh needed; refresh may store
// - store enable bit: refresh stores all
// - no activation during store period
// - buffer-only mode never commits writes
module pbf_front_end
  import pbf_pkg::*;
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // host command pins
  input  wire pbf_cmd_t         cmd_in,
  output logic                  cmd_ready,
  // register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  // core beat stream
  output logic                  beat_valid,
  input  wire logic             beat_ready,
  output logic                  beat_write,
  output logic                  beat_commit,
  output logic [3:0]            beat_bank,
  output logic [ROW_W-1:0]      beat_row,
  output logic [COL_W-1:0]      beat_col_even,
  output logic [COL_W-1:0]      beat_col_odd,
  output logic                  beat_last,
  // store request to the array
  output logic                  store_req
);
  ////////////////////////////////////////////////////////////////////////
  // reset release and input capture
  logic     rst_s1_r;
  logic     rst_n;
  pbf_cmd_t cmd_s1_r;
  pbf_cmd_t cmd_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_s1_r <= '0;
      cmd_r    <= '0;
    end else begin
      cmd_s1_r <= cmd_in;
      cmd_r    <= cmd_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [31:0] base_config_r;
  logic [31:0] refresh_config_r;
  logic [31:0] org_r;
  logic        choice_en;
  logic        fixed_chop;
  logic        buffer_only_write_mode;
  logic        store_en;
  logic        wide;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_config_r    <= BASE_CFG_RST;
      refresh_config_r <= REFR_CFG_RST;
      org_r            <= ORG_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_BASE_CFG) begin
        base_config_r <= reg_wdata;
      end
      if (reg_addr == REG_REFR_CFG) begin
        refresh_config_r <= reg_wdata;
      end
      if (reg_addr == REG_ORG) begin
        org_r <= reg_wdata;
      end
    end
  end

  assign choice_en              = base_config_r[BASE_CHOICE_BIT];
  assign fixed_chop             = base_config_r[BASE_FIXCHOP_BIT];
  assign buffer_only_write_mode = base_config_r[BASE_BUFONLY_BIT];
  assign store_en               = refresh_config_r[REFR_STORE_BIT];
  assign wide                   = org_r[ORG_WIDE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // command decode
  logic [3:0]       cmd_bank_idx;
  logic             is_act;
  logic             is_rw;
  logic             is_ref;
  logic             is_pre;
  logic             store_busy;
  logic [3:0]       store_cnt_r;
  logic [NUM_BANKS-1:0] bank_open_r;
  logic [ROW_W-1:0] open_row [NUM_BANKS];
  logic             buf_in_ready;
  logic             push;
  pbf_burst_t       push_data;
  logic             refuse;
  logic [15:0]      refused_cnt_r;

  // x16 uses one group bit and eight banks
  // bank index map
  assign cmd_bank_idx = wide ? {1'b0, cmd_r.group_select_bits[0], cmd_r.bank}
                             : {cmd_r.group_select_bits, cmd_r.bank};
  assign is_act     = (cmd_r.code == CMD_ACT);
  assign is_rw      = (cmd_r.code == CMD_RD) || (cmd_r.code == CMD_WR);
  assign is_ref     = (cmd_r.code == CMD_REF);
  assign is_pre     = (cmd_r.code == CMD_PRE);
  assign store_busy = (store_cnt_r != 4'h0);
  assign push       = is_rw && bank_open_r[cmd_bank_idx] && buf_in_ready;
  assign refuse     = (is_act && store_busy) || (is_rw && !push);

  always_comb begin
    push_data            = '0;
    push_data.is_write   = (cmd_r.code == CMD_WR);
    push_data.bank_idx   = cmd_bank_idx;
    push_data.row        = open_row[cmd_bank_idx];
    push_data.col        = cmd_r.addr[COL_W-1:0];
    push_data.auto_close = cmd_r.addr[AUTO_CLOSE_BIT];
    push_data.chop       = choice_en ? !cmd_r.addr[BURST_LEN_BIT] : fixed_chop;
    push_data.commit     = push_data.is_write && !buffer_only_write_mode;
  end

  ////////////////////////////////////////////////////////////////////////
  // bank state
  // row capture on activate
  always_ff @(posedge sys_clk) begin
    if (is_act && !store_busy) begin
      open_row[cmd_bank_idx] <= cmd_r.addr;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_open_r <= '0;
    end else if (is_ref && store_en && !store_busy) begin
      bank_open_r <= '0;
    end else if (is_act && !store_busy) begin
      bank_open_r[cmd_bank_idx] <= 1'b1;
    end else if (is_pre || (push && push_data.auto_close)) begin
      bank_open_r[cmd_bank_idx] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // store timing
  // refresh stores only when enabled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_cnt_r <= 4'h0;
      store_req   <= 1'b0;
    end else begin
      store_req <= 1'b0;
      if (is_ref && store_en && !store_busy) begin
        store_cnt_r <= 4'(STORE_CYC);
        store_req   <= 1'b1;
      end else if (store_busy) begin
        store_cnt_r <= store_cnt_r - 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_cnt_r <= 16'h0000;
      cmd_ready     <= 1'b0;
    end else begin
      cmd_ready <= buf_in_ready;
      if (refuse && (refused_cnt_r != 16'hffff)) begin
        refused_cnt_r <= refused_cnt_r + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // descriptor buffer
  logic       buf_out_valid;
  logic       buf_out_ready;
  pbf_burst_t buf_out_data;

  pbf_fifo #(
    .W     ($bits(pbf_burst_t)),
    .DEPTH (2)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (push_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // burst sequencer
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b01,
    ENG_RUN  = 2'b10
  } pbf_eng_t;

  pbf_eng_t   eng_r;
  pbf_burst_t desc_r;
  logic [1:0] idx_r;
  logic       adv;
  logic [1:0] last_idx;

  // sequential order, wrapping inside the burst's aligned block
  function automatic logic [COL_W-1:0] pair_col(input logic [COL_W-1:0] col, input logic chop,
                                                input logic [1:0] k, input logic odd);
    logic [2:0] lo;
    lo = col[2:0] + {k, 1'b0} + {2'b00, odd};
    if (chop) begin
      lo[2] = col[2];
    end
    return {col[COL_W-1:3], lo};
  endfunction

  assign adv           = !beat_valid || beat_ready;
  assign buf_out_ready = (eng_r == ENG_IDLE);
  assign last_idx      = desc_r.chop ? 2'(CHOP_CLKS - 1) : 2'(FULL_CLKS - 1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eng_r  <= ENG_IDLE;
      desc_r <= '0;
      idx_r  <= 2'h0;
    end else begin
      case (eng_r)
        ENG_IDLE: begin
          if (buf_out_valid) begin
            desc_r <= buf_out_data;
            idx_r  <= 2'h0;
            eng_r  <= ENG_RUN;
          end
        end
        ENG_RUN: begin
          if (adv) begin
            idx_r <= idx_r + 2'h1;
            if (idx_r == last_idx) begin
              eng_r <= ENG_IDLE;
            end
          end
        end
        default: begin
          eng_r <= ENG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      beat_valid    <= 1'b0;
      beat_write    <= 1'b0;
      beat_commit   <= 1'b0;
      beat_bank     <= 4'h0;
      beat_row      <= '0;
      beat_col_even <= '0;
      beat_col_odd  <= '0;
      beat_last     <= 1'b0;
    end else if (adv) begin
      beat_valid    <= (eng_r == ENG_RUN);
      beat_write    <= desc_r.is_write;
      beat_commit   <= desc_r.commit;
      beat_bank     <= desc_r.bank_idx;
      beat_row      <= desc_r.row;
      beat_col_even <= pair_col(desc_r.col, desc_r.chop, idx_r, 1'b0);
      beat_col_odd  <= pair_col(desc_r.col, desc_r.chop, idx_r, 1'b1);
      beat_last     <= (eng_r == ENG_RUN) && (idx_r == last_idx);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_BASE_CFG: reg_rdata <= base_config_r;
        REG_REFR_CFG: reg_rdata <= refresh_config_r;
        REG_ORG:      reg_rdata <= org_r;
        REG_STATUS:   reg_rdata <= {15'h0000, store_busy, bank_open_r};
        REG_REFUSED:  reg_rdata <= {16'h0000, refused_cnt_r};
        default:      reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_STORE_HOLD: assert property (store_req |-> store_busy [*8])
    else $error("store period shorter than expected");
  AST_ACT_REFUSED: assert property ((is_act && store_busy) |=> !bank_open_r[$past(cmd_bank_idx)])
    else $error("bank opened during store period");
  AST_REF_NOSTORE: assert property ((is_ref && !store_en) |=> !store_req)
    else $error("refresh stored while store disabled");
  AST_REF_STORE: assert property ((is_ref && store_en && !store_busy) |=> store_req && bank_open_r == '0)
    else $error("enabled refresh did not store all banks");
  AST_NO_COMMIT: assert property ((push && buffer_only_write_mode) |-> !push_data.commit)
    else $error("write committed in buffer only mode");
  AST_CHOICE: assert property ((push && choice_en) |-> push_data.chop != cmd_r.addr[BURST_LEN_BIT])
    else $error("burst length choice inverted");
  AST_X16_MAP: assert property ((push && wide) |-> !push_data.bank_idx[3])
    else $error("x16 bank index out of range");
  AST_PAIR: assert property (beat_valid |-> beat_col_odd[COL_W-1:1] == beat_col_even[COL_W-1:1])
    else $error("beat pair split across column pairs");
  AST_BURST_LEN: assert property ($rose(eng_r == ENG_RUN) && !desc_r.chop && adv
                                  ##1 beat_ready [*3] |=> beat_last)
    else $error("full burst did not end after four clocks");
endmodule
`default_nettype wire

// ---- verification/pbf_host_model.sv ----
// host controller model driving the command pins
`default_nettype none
module pbf_host_model
  import pbf_pkg::*;
(
  // clock
  input  wire logic sys_clk,
  // command pins
  output var pbf_cmd_t cmd_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial cmd_in = '0;

  //////////////////////////////////////////////////////////////////////////////
  // idle keeps a no-op up while the address lines toggle every cycle
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      cmd_in <= pbf_cmd_t'({CMD_NOP, ~cmd_in[19:0]});
    end
  endtask

  // a command stands for exactly one cycle
  task automatic issue(input pbf_cmd_code_t c, input logic [1:0] g, input logic [1:0] b, input logic [15:0] a);
    @(posedge sys_clk);
    cmd_in <= '{code: c, group_select_bits: g, bank: b, addr: a};
    idle(1);
  endtask

  task automatic access(input pbf_cmd_code_t c, input logic [1:0] g, input logic [1:0] b, input logic [15:0] row,
                        input logic [15:0] a);
    issue(CMD_ACT, g, b, row);
    idle(3);
    issue(c, g, b, a);
  endtask

  // wait out init or store period
  task automatic hold_off();
    idle(STORE_CYC + 4);
  endtask
endmodule
`default_nettype wire

// ---- verification/test_pbf_front_end.sv ----
// self-checking bench of the bank access front end
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module test_pbf_front_end
  import pbf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic             sys_clk;
  logic             resetn;
  pbf_cmd_t         cmd_in;
  logic             cmd_ready;
  logic [3:0]       reg_addr;
  logic [31:0]      reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [31:0]      reg_rdata;
  logic             beat_valid, beat_ready, beat_write, beat_commit, beat_last, store_req;
  logic [3:0]       beat_bank;
  logic [ROW_W-1:0] beat_row;
  logic [COL_W-1:0] beat_col_even, beat_col_odd;
  int               err_count = 0;
  int               samples_checked = 0;
  int               cyc = 0;
  int               stores = 0;
  logic [31:0]      exp_ref = '0;

  always #25 sys_clk = ~sys_clk;

  pbf_host_model pbf_host_model_i (.sys_clk(sys_clk), .cmd_in(cmd_in));

  pbf_front_end pbf_front_end_i (
    .sys_clk(sys_clk), .resetn(resetn), .cmd_in(cmd_in), .cmd_ready(cmd_ready),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .beat_valid(beat_valid), .beat_ready(beat_ready), .beat_write(beat_write), .beat_commit(beat_commit),
    .beat_bank(beat_bank), .beat_row(beat_row), .beat_col_even(beat_col_even), .beat_col_odd(beat_col_odd),
    .beat_last(beat_last), .store_req(store_req));

  always @(posedge sys_clk) begin
    cyc++;
    if (store_req === 1'b1) stores++;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [3:0] a, input logic [31:0] ex);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    `CHK("reg_rdata", ex, reg_rdata)
  endtask

  // cm is the commit flag expected on every pair
  task automatic take_burst(input int pairs, input logic [6:0] c0, input logic [3:0] bk, input logic [15:0] row,
                            input logic wr, input logic cm);
    int t;
    for (int k = 0; k < pairs; k++) begin
      t = 0;
      do begin
        @(posedge sys_clk);
        t++;
      end while (!(beat_valid === 1'b1 && beat_ready === 1'b1) && t < 60);
      `CHK("beat", {bk, row, wr, cm, c0 + 7'(2 * k), c0 + 7'(2 * k + 1), k == pairs - 1},
           {beat_bank, beat_row, beat_write, beat_commit, beat_col_even, beat_col_odd, beat_last})
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < 5; i++) reg_check(4'(i), 32'h0000_0000);
    reg_write(4'h9, 32'hffff_ffff);
    reg_check(4'h9, 32'h0000_0000);
    reg_write(REG_BASE_CFG, 32'h0000_0001);
    reg_check(REG_BASE_CFG, 32'h0000_0001);
  endtask

  task automatic t_full_read();
    pbf_host_model_i.access(CMD_RD, 2'h1, 2'h2, 16'h1234, 16'h1000);
    take_burst(4, 7'h00, 4'h6, 16'h1234, 1'b0, 1'b0);
    reg_check(REG_STATUS, 32'h0000_0040);
  endtask

  task automatic t_chop_close();
    pbf_host_model_i.issue(CMD_RD, 2'h1, 2'h2, 16'h0404);
    take_burst(2, 7'h04, 4'h6, 16'h1234, 1'b0, 1'b0);
    reg_check(REG_STATUS, 32'h0000_0000);
    pbf_host_model_i.issue(CMD_RD, 2'h1, 2'h2, 16'h1000);
    exp_ref++;
    pbf_host_model_i.idle(12);
    `CHK("beat_valid", 1'b0, beat_valid)
    reg_check(REG_REFUSED, exp_ref);
  endtask

  task automatic t_writes();
    pbf_host_model_i.access(CMD_WR, 2'h0, 2'h1, 16'h0002, 16'h1008);
    take_burst(4, 7'h08, 4'h1, 16'h0002, 1'b1, 1'b1);
    reg_write(REG_BASE_CFG, 32'h0000_2001);
    pbf_host_model_i.issue(CMD_WR, 2'h0, 2'h1, 16'h1010);
    take_burst(4, 7'h10, 4'h1, 16'h0002, 1'b1, 1'b0);
    // choice off: fixed chop applies even with the length bit high
    reg_write(REG_BASE_CFG, 32'h0000_0002);
    pbf_host_model_i.issue(CMD_RD, 2'h0, 2'h1, 16'h1018);
    take_burst(2, 7'h18, 4'h1, 16'h0002, 1'b0, 1'b0);
    reg_write(REG_BASE_CFG, 32'h0000_0001);
  endtask

  task automatic t_wide();
    reg_write(REG_ORG, 32'h0000_0001);
    pbf_host_model_i.issue(CMD_ACT, 2'h3, 2'h1, 16'h0077);
    pbf_host_model_i.idle(3);
    reg_check(REG_STATUS, 32'h0000_0022);
    reg_write(REG_ORG, 32'h0000_0000);
  endtask

  task automatic t_stall();
    beat_ready <= 1'b0;
    for (int i = 0; i < 3; i++) pbf_host_model_i.issue(CMD_RD, 2'h0, 2'h1, 16'(8 * i));
    pbf_host_model_i.idle(12);
    `CHK("cmd_ready", 1'b0, cmd_ready)
    `CHK("beat_valid", 1'b1, beat_valid)
    beat_ready <= 1'b1;
    for (int i = 0; i < 3; i++) take_burst(2, 7'(8 * i), 4'h1, 16'h0002, 1'b0, 1'b0);
    pbf_host_model_i.idle(4);
    `CHK("cmd_ready", 1'b1, cmd_ready)
    reg_check(REG_REFUSED, exp_ref);
  endtask

  task automatic t_store();
    int s0;
    s0 = stores;
    pbf_host_model_i.issue(CMD_REF, 2'h0, 2'h0, 16'h0000);
    pbf_host_model_i.idle(12);
    `CHK("store_count", 0, stores - s0)
    reg_check(REG_STATUS, 32'h0000_0022);
    reg_write(REG_REFR_CFG, 32'h0000_0100);
    pbf_host_model_i.issue(CMD_REF, 2'h0, 2'h0, 16'h0000);
    pbf_host_model_i.issue(CMD_ACT, 2'h2, 2'h0, 16'h0005);
    exp_ref++;
    pbf_host_model_i.idle(3);
    reg_check(REG_STATUS, 32'h0001_0000);
    pbf_host_model_i.hold_off();
    `CHK("store_count", 1, stores - s0)
    pbf_host_model_i.issue(CMD_ACT, 2'h2, 2'h0, 16'h0005);
    pbf_host_model_i.idle(3);
    reg_check(REG_STATUS, 32'h0000_0100);
    reg_check(REG_REFUSED, exp_ref);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk    = 1'b0;
    resetn     = 1'b0;
    reg_addr   = 4'h0;
    reg_wdata  = 32'h0000_0000;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    beat_ready = 1'b1;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    pbf_host_model_i.hold_off();
    t_regs();
    t_full_read();
    t_chop_close();
    t_writes();
    t_wide();
    t_stall();
    t_store();
    final_report();
  end
endmodule
`default_nettype wire
